// ### verilog/aeb_master.v
/*
 * external bus master: strobes, sizing, dynamic port width, byte
 * write enables, arbitration, locked cycles, chip selects, interrupt
 * level encoding, reset line stretching and halt reporting.
 * assumes a cpu-side request port on clk_sys and external pins that
 * are asynchronous; open-drain pins are split into in/out/oe.
 */
`include "aeb_defines.vh"

module aeb_master #(
	parameter RST_CYC = `AEB_RST_MIN_CYC
) (
	input  wire        clk_sys,            // system clock, 200 MHz
	input  wire        resetn,             // async reset, active low
	input  wire        req_valid,          // cpu transfer request
	input  wire [23:0] req_addr,           // cpu byte address
	input  wire [2:0]  req_space,          // cpu space code
	input  wire [1:0]  req_size,           // cpu remaining bytes code
	input  wire        req_read,           // 1 read, 0 write
	input  wire        req_locked,         // part of locked sequence
	input  wire [15:0] req_wdata,          // write data, big endian
	input  wire [3:0]  cs_match,           // address decode per select
	input  wire        cs0_auto_vector_req_n_mode,      // select 0 used as autovector
	input  wire [6:0]  irq_pin_mode,       // 1 = interrupt, 0 = parallel io
	input  wire [6:0]  irq_mask_lvl,       // mask levels 1..6 (bit6 ignored)
	input  wire        sw_reset_req,       // reset instruction pulse
	input  wire        double_fault,       // cpu double bus fault
	output reg         req_done,           // cycle ended pulse
	output reg         req_fault,          // bus fault pulse
	output reg         req_retry,          // retry requested pulse
	output reg         req_port8,          // ended as 8-bit port
	output reg         req_auto_vector_req_n,           // autovector taken
	output reg  [15:0] req_rdata,          // read data
	output reg  [2:0]  irq_level,          // highest pending level
	output reg  [6:0]  port_b_in,          // parallel io input values
	output reg         bus_suspended,      // suspended by halt pin low, own pull included
	output reg         ext_reset_seen,     // whole-chip reset request
	input  wire [15:0] data_lines_i,       // data pins in
	output reg  [15:0] data_lines_o,       // data pins out
	output reg         data_lines_oe,      // data pins drive enable
	output reg  [2:0]  space_code,         // address space code
	output reg  [23:0] addr_out,           // address bus
	output reg  [3:0]  select_out_n,       // chip selects
	input  wire        auto_vector_req_n,  // autovector pin in
	input  wire [6:0]  int_level_req_n,    // interrupt pins, bit6 = level 7
	input  wire        size_ack_hi_n,      // size ack high
	input  wire        size_ack_lo_n,      // size ack low
	output reg         addr_strobe_n,      // address strobe
	output reg         data_strobe_n,      // data strobe
	output reg         xfer_size_hi,       // size bit 1
	output reg         xfer_size_lo,       // size bit 0
	output reg         read_write,         // direction
	input  wire        mastership_request_n, // bus request
	output reg         mastership_grant_n, // bus grant
	input  wire        grant_ack_n,        // grant acknowledge
	output reg         locked_cycle_n,     // locked cycle
	output reg         upper_byte_wr_n,    // upper lane write enable
	output reg         lower_byte_wr_n,    // lower lane write enable
	input  wire        reset_line_i,       // reset pin in
	output reg         reset_line_o,       // reset pin out, always 0
	output reg         reset_line_oe,      // reset pin pull-down
	input  wire        suspend_n_i,        // halt pin in
	output reg         suspend_n_o,        // halt pin out, always 0
	output reg         suspend_n_oe,       // halt pin pull-down
	input  wire        bus_fault_n,        // bus fault
	output reg         sys_clock_out       // bus timing reference
);
	localparam SW = 15;

	// two-stage synchronisers; stage one read only by stage two
	reg [SW-1:0] sync1_q;
	reg [SW-1:0] sync2_q;
	wire [SW-1:0] pins_raw = {int_level_req_n, auto_vector_req_n, size_ack_hi_n,
		size_ack_lo_n, mastership_request_n, grant_ack_n, reset_line_i,
		suspend_n_i, bus_fault_n};
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= {SW{1'b1}};
			sync2_q <= {SW{1'b1}};
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end
	wire [6:0] irq_s   = sync2_q[14:8];
	wire       auto_vector_req_n_s  = sync2_q[7];
	wire [1:0] ack_s   = sync2_q[6:5];
	wire       br_s    = sync2_q[4];
	wire       grant_ack_n_s = sync2_q[3];
	wire       rst_s   = sync2_q[2];
	wire       halt_s  = sync2_q[1];
	wire       bus_fault_n_s  = sync2_q[0];

	// priority encoder over enabled, unmasked levels
	function [2:0] aeb_prio;
		input [6:0] act;
		input [6:0] msk;
		integer     k;
		begin
			aeb_prio = 3'h0;
			for (k = 0; k < 7; k = k + 1)
				if (act[k] && (k == 6 || !msk[k]))
					aeb_prio = k[2:0] + 3'h1;
		end
	endfunction

	// counter wide enough for the stretch; load cut to width on purpose
	localparam RCW = (RST_CYC > 1024) ? 16 : `AEB_RST_CNT_W;
	localparam [RCW-1:0] RST_LOAD = RST_CYC - 1;

	reg  [2:0]     st_q;
	reg  [RCW-1:0] rcnt_q;
	reg            int_rst_q;
	reg  [1:0]     own_rst_q;
	reg            locked_q;
	wire           ack_done = (ack_s != `AEB_ACK_WAIT);
	wire           retry_in = !bus_fault_n_s && !halt_s;

	// self-driven reset stretch; the cpu side is not reset by it
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			int_rst_q <= 1'b0;
			rcnt_q <= {RCW{1'b0}};
			own_rst_q <= 2'h0;
		end else begin
			// our own pull echoes through the synchroniser for two cycles
			own_rst_q <= {own_rst_q[0], reset_line_oe};
			if (sw_reset_req && !int_rst_q) begin
				int_rst_q <= 1'b1;
				rcnt_q <= RST_LOAD;
			end else if (int_rst_q) begin
				if (rcnt_q == {RCW{1'b0}})
					int_rst_q <= 1'b0;
				else
					rcnt_q <= rcnt_q - 1'b1;
			end
		end
	end

	// interrupt levels and raw port values from the synced pins
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_level <= 3'h0;
			port_b_in <= 7'h00;
		end else begin
			irq_level <= aeb_prio(~irq_s & irq_pin_mode, irq_mask_lvl);
			port_b_in <= irq_s;
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= `AEB_ST_IDLE;
			locked_q <= 1'b0;
			req_done <= 1'b0;
			req_fault <= 1'b0;
			req_retry <= 1'b0;
			req_port8 <= 1'b0;
			req_auto_vector_req_n <= 1'b0;
			req_rdata <= 16'h0000;
			bus_suspended <= 1'b0;
			ext_reset_seen <= 1'b0;
			data_lines_o <= 16'h0000;
			data_lines_oe <= 1'b0;
			space_code <= `AEB_SC_SUPV_PROG;
			addr_out <= 24'h000000;
			select_out_n <= 4'hF;
			addr_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			xfer_size_hi <= 1'b0;
			xfer_size_lo <= 1'b0;
			read_write <= 1'b1;
			mastership_grant_n <= 1'b1;
			locked_cycle_n <= 1'b1;
			upper_byte_wr_n <= 1'b1;
			lower_byte_wr_n <= 1'b1;
			reset_line_o <= 1'b0;
			reset_line_oe <= 1'b0;
			suspend_n_o <= 1'b0;
			suspend_n_oe <= 1'b0;
			sys_clock_out <= 1'b0;
		end else begin
			req_done <= 1'b0;
			req_fault <= 1'b0;
			req_retry <= 1'b0;
			req_auto_vector_req_n <= 1'b0;
			// half rate; toggles from the first edge so it never stalls
			sys_clock_out <= ~sys_clock_out;
			bus_suspended <= !halt_s && bus_fault_n_s;
			suspend_n_oe <= double_fault;
			// external low resets the chip; our own pull and its echo do not
			ext_reset_seen <= !rst_s && !int_rst_q && !reset_line_oe &&
				(own_rst_q == 2'h0);
			reset_line_oe <= int_rst_q;
			case (st_q)
				`AEB_ST_IDLE: begin
					addr_strobe_n <= 1'b1;
					data_strobe_n <= 1'b1;
					data_lines_oe <= 1'b0;
					select_out_n <= 4'hF;
					upper_byte_wr_n <= 1'b1;
					lower_byte_wr_n <= 1'b1;
					// ownership never moves mid locked sequence
					if (!br_s && !locked_q) begin
						mastership_grant_n <= 1'b0;
						st_q <= `AEB_ST_GRANT;
					end else if (req_valid && halt_s) begin
						addr_out <= req_addr;
						space_code <= req_space;
						xfer_size_hi <= req_size[1];
						xfer_size_lo <= req_size[0];
						read_write <= req_read;
						locked_q <= req_locked;
						locked_cycle_n <= !req_locked;
						data_lines_o <= req_wdata;
						data_lines_oe <= !req_read;
						st_q <= `AEB_ST_ADDR;
					end else if (!locked_q) begin
						locked_cycle_n <= 1'b1;
					end
				end
				`AEB_ST_ADDR: begin
					// strobe follows one cycle after attributes settle
					addr_strobe_n <= 1'b0;
					data_strobe_n <= 1'b0;
					// cs0 is boot select until reprogrammed as autovector
					select_out_n <= ~(cs_match & {3'h7, !cs0_auto_vector_req_n_mode});
					if (!read_write) begin
						upper_byte_wr_n <= addr_out[0] &&
							{xfer_size_hi, xfer_size_lo} == `AEB_SIZ_BYTE;
						lower_byte_wr_n <= !(addr_out[0] ||
							{xfer_size_hi, xfer_size_lo} != `AEB_SIZ_BYTE);
					end
					st_q <= `AEB_ST_DATA;
				end
				`AEB_ST_DATA: begin
					if (!bus_fault_n_s) begin
						req_fault <= halt_s;
						req_retry <= retry_in;
						st_q <= `AEB_ST_END;
					end else if (cs0_auto_vector_req_n_mode && !auto_vector_req_n_s &&
						space_code == `AEB_SC_CPU_SPACE) begin
						req_auto_vector_req_n <= 1'b1;
						st_q <= `AEB_ST_END;
					end else if (ack_done) begin
						req_port8 <= (ack_s == `AEB_ACK_PORT8);
						req_done <= 1'b1;
						req_rdata <= data_lines_i;
						st_q <= `AEB_ST_END;
					end
				end
				`AEB_ST_END: begin
					addr_strobe_n <= 1'b1;
					data_strobe_n <= 1'b1;
					upper_byte_wr_n <= 1'b1;
					lower_byte_wr_n <= 1'b1;
					select_out_n <= 4'hF;
					// wait for the slave to let go before the next cycle
					if (ack_s == `AEB_ACK_WAIT && bus_fault_n_s)
						st_q <= `AEB_ST_IDLE;
				end
				`AEB_ST_GRANT: begin
					if (!grant_ack_n_s)
						mastership_grant_n <= 1'b1;
					if (br_s && grant_ack_n_s)
						st_q <= `AEB_ST_IDLE;
				end
				default: st_q <= `AEB_ST_IDLE;
			endcase
		end
	end
endmodule // aeb_master

// ### verilog/aeb_defines.vh
/*
 * constants for the asynchronous external bus master: space codes,
 * size encodings, acknowledge decoding and reset stretch timing.
 * assumes inclusion by bare name from the design file.
 */
`ifndef AEB_DEFINES_VH
`define AEB_DEFINES_VH

`define AEB_SC_RSVD0       3'h0
`define AEB_SC_USER_DATA   3'h1
`define AEB_SC_USER_PROG   3'h2
`define AEB_SC_RSVD3       3'h3
`define AEB_SC_RSVD4       3'h4
`define AEB_SC_SUPV_DATA   3'h5
`define AEB_SC_SUPV_PROG   3'h6
`define AEB_SC_CPU_SPACE   3'h7

`define AEB_SIZ_LONG       2'h0
`define AEB_SIZ_BYTE       2'h1
`define AEB_SIZ_WORD       2'h2
`define AEB_SIZ_THREE      2'h3

`define AEB_ACK_WAIT       2'h3
`define AEB_ACK_PORT8      2'h2
`define AEB_ACK_PORT16     2'h1
`define AEB_ACK_RSVD16     2'h0

`define AEB_CLK_NS         5
`define AEB_RST_MIN_CYC    512
`define AEB_RST_CNT_W      10

`define AEB_ST_IDLE        3'h0
`define AEB_ST_ADDR        3'h1
`define AEB_ST_DATA        3'h2
`define AEB_ST_END         3'h3
`define AEB_ST_GRANT       3'h4
`define AEB_ST_RESET       3'h5

`endif

// ### sim/aeb_master_asserts.sv
/* pin checker for aeb_master.
   assumes it is bound onto the design and sees only its ports. */
module aeb_chk #(
	parameter RST_CYC = 512
) (
	input wire logic       clk_sys,            // clock
	input wire logic       resetn,             // reset
	input wire logic       double_fault,       // halt cause
	input wire logic [2:0] space_code,         // space
	input wire logic       read_write,         // direction
	input wire logic       addr_strobe_n,      // strobe
	input wire logic       data_strobe_n,      // strobe
	input wire logic       data_lines_oe,      // drive
	input wire logic       size_ack_hi_n,      // ack
	input wire logic       size_ack_lo_n,      // ack
	input wire logic       locked_cycle_n,     // lock
	input wire logic       mastership_grant_n, // grant
	input wire logic       reset_line_oe,      // reset pull
	input wire logic       ext_reset_seen,     // external reset flag
	input wire logic       suspend_n_oe,       // halt pull
	input wire logic       sys_clock_out       // clock out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] cnt_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// length of the current reset pull, read at its release
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			cnt_q <= 10'h000;
		else
			cnt_q <= reset_line_oe ? cnt_q + 10'h001 : 10'h000;
	end
	attr_hold_a: assert property (!addr_strobe_n && $past(!addr_strobe_n)
		|-> $stable({space_code, read_write})) else $error("attributes moved");
	space_legal_a: assert property (!addr_strobe_n |-> !(space_code inside {3'h0, 3'h3, 3'h4}))
		else $error("reserved space code");
	wr_data_a: assert property (!data_strobe_n && !read_write |-> data_lines_oe)
		else $error("write data not driven");
	ack_end_a: assert property (!addr_strobe_n && !(size_ack_hi_n && size_ack_lo_n)
		|-> ##[1:6] addr_strobe_n) else $error("cycle not ended");
	lock_hold_a: assert property (!locked_cycle_n |-> mastership_grant_n)
		else $error("grant in locked");
	rst_len_a: assert property ($fell(reset_line_oe) |-> cnt_q >= RST_CYC)
		else $error("reset too short");
	halt_out_a: assert property ($rose(double_fault) |-> ##[1:3] suspend_n_oe)
		else $error("halt not driven");
	self_rst_a: assert property (reset_line_oe |-> !ext_reset_seen)
		else $error("own reset taken as external");
	clk_out_a: assert property ($past(resetn) |-> sys_clock_out != $past(sys_clock_out))
		else $error("clock out stuck");
	cover property (!size_ack_lo_n && !addr_strobe_n);
	cover property ($fell(mastership_grant_n));
	cover property ($fell(reset_line_oe));
endmodule // aeb_chk
bind aeb_master aeb_chk #(.RST_CYC(RST_CYC)) u_chk (.*);

// ### sim/aeb_slave.sv
/* slave model on the bus pins: two wait states, then the answer set by mode.
   assumes data_lines_i is fed only from here. */
module aeb_slave (
	input wire logic        clk_sys,           // clock
	input wire logic [2:0]  mode,              // 0 w16 1 w8 2 fault 3 retry 4 auto_vector_req_n
	input wire logic        data_strobe_n,     // strobe
	input wire logic        read_write,        // direction
	input wire logic [15:0] data_lines_o,      // device data
	input wire logic        data_lines_oe,     // device drives
	output logic [15:0]     data_lines_i,      // bus level
	output logic            size_ack_hi_n,     // ack
	output logic            size_ack_lo_n,     // ack
	output logic            bus_fault_n,       // fault
	output logic            halt_n,            // halt pull
	output logic            auto_vector_req_n  // autovector
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_q;
	logic [1:0]  wait_q;
	logic        hit;
	// waits make the device hold its strobes
	always @(posedge clk_sys) begin
		wait_q <= data_strobe_n ? 2'h0 : (wait_q == 2'h2 ? 2'h2 : wait_q + 2'h1);
		last_q <= data_lines_i;
	end
	assign hit = !data_strobe_n && wait_q == 2'h2;
	assign size_ack_hi_n = !(hit && mode == 3'h0);
	assign size_ack_lo_n = !(hit && mode == 3'h1);
	assign bus_fault_n = !(hit && (mode == 3'h2 || mode == 3'h3));
	assign halt_n = !(hit && mode == 3'h3);
	assign auto_vector_req_n = !(hit && mode == 3'h4);
	// released bus toggles so stale data never looks valid
	assign data_lines_i = data_lines_oe ? data_lines_o
		: (!data_strobe_n && read_write) ? 16'hC35A : ~last_q;
endmodule // aeb_slave

// ### sim/testbench.sv
/* self-checking bench for aeb_master with a slave model on its pins.
   assumes a 200 MHz clock and the reset stretch cut to 8 cycles. */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, resetn, req_valid, req_read, req_locked, cs0_auto_vector_req_n_mode, c_rw, c_lk;
	logic        sw_reset_req, double_fault, mastership_request_n, grant_ack_n;
	logic [23:0] req_addr;
	logic [15:0] req_wdata, c_wd, r_d;
	logic [6:0]  irq_pin_mode, irq_mask_lvl, int_level_req_n;
	logic [4:0]  r_k;
	logic [3:0]  cs_match, c_cs;
	logic [2:0]  req_space, mode, c_sc;
	logic [1:0]  req_size, c_sz, c_ln;
	int          bad_count = 0, cmp_count = 0;
	wire         req_done, req_fault, req_retry, req_port8, req_auto_vector_req_n, bus_suspended, halt_n;
	wire         ext_reset_seen, data_lines_oe, addr_strobe_n, data_strobe_n, read_write;
	wire         xfer_size_hi, xfer_size_lo, mastership_grant_n, locked_cycle_n, bus_fault_n;
	wire         upper_byte_wr_n, lower_byte_wr_n, reset_line_o, reset_line_oe, suspend_n_o;
	wire         suspend_n_oe, sys_clock_out, auto_vector_req_n, size_ack_hi_n, size_ack_lo_n;
	wire [23:0]  addr_out;
	wire [15:0]  req_rdata, data_lines_o, data_lines_i;
	wire [6:0]   port_b_in;
	wire [3:0]   select_out_n;
	wire [2:0]   irq_level, space_code;
	// open-drain pins sit low while any party pulls
	wire         reset_line_i = !reset_line_oe;
	wire         suspend_n_i = halt_n && !suspend_n_oe;
	aeb_master #(.RST_CYC(8)) DUT (.*);
	aeb_slave u_slave (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one cpu request; pins captured under the strobe, answer at the pulse
	task automatic bus(input [2:0] m, sc, input [23:0] a, input [1:0] sz, input rd, lk);
		int n = 0;
		@(posedge clk_sys);
		{mode, req_space, req_addr, req_size, req_read, req_locked} <= {m, sc, a, sz, rd, lk};
		req_wdata <= 16'h5A00 + a[7:0];
		req_valid <= 1'b1;
		do begin @(posedge clk_sys); n++; end while (addr_strobe_n !== 1'b0 && n < 50);
		{c_sc, c_sz, c_rw, c_lk, c_ln, c_cs, c_wd} = {space_code, xfer_size_hi, xfer_size_lo,
			read_write, locked_cycle_n, upper_byte_wr_n, lower_byte_wr_n, select_out_n, data_lines_o};
		do begin @(posedge clk_sys); n++; end
		while ({req_done, req_fault, req_retry, req_auto_vector_req_n} === 4'h0 && n < 100);
		{r_k, r_d} = {req_done, req_fault, req_retry, req_auto_vector_req_n, req_port8, req_rdata};
		req_valid <= 1'b0;
		chk(n < 100, 1'b1);
	endtask
	task automatic wait_grant(input logic v);
		int n = 0;
		do begin @(posedge clk_sys); n++; end while (mastership_grant_n !== v && n < 20);
		chk(mastership_grant_n, v);
	endtask
	task automatic t_writes;
		logic [2:0] sc [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h1};
		for (int i = 0; i < 6; i++) begin
			bus(3'h0, sc[i], 24'h000100 + i[2], i[1:0], 1'b0, 1'b0);
			chk(c_sc, sc[i]);
			chk(c_sz, i[1:0]);
			chk(c_rw, 1'b0);
			chk(c_ln, i[1:0] == 2'h1 ? {i[2], !i[2]} : 2'h0);
			if (i == 2) chk(c_wd, 16'h5A00);
			chk(r_k, 5'h10);
		end
	endtask
	task automatic t_reads;
		cs_match <= 4'h1;
		bus(3'h0, 3'h6, 24'h000000, 2'h2, 1'b1, 1'b1);
		chk(c_cs, 4'hE);
		chk(c_rw, 1'b1);
		chk(c_lk, 1'b0);
		chk(r_d, 16'hC35A);
		bus(3'h1, 3'h5, 24'h000010, 2'h2, 1'b1, 1'b0);
		chk(r_k, 5'h11);
		bus(3'h2, 3'h5, 24'h000300, 2'h2, 1'b1, 1'b0);
		chk(r_k[3:2], 2'h2);
		bus(3'h3, 3'h5, 24'h000302, 2'h2, 1'b1, 1'b0);
		chk(r_k[3:2], 2'h1);
		cs_match <= 4'h0;
		cs0_auto_vector_req_n_mode <= 1'b1;
		bus(3'h4, 3'h7, 24'hFFFFF6, 2'h1, 1'b1, 1'b0);
		chk(r_k[1], 1'b1);
		cs0_auto_vector_req_n_mode <= 1'b0;
	endtask
	task automatic t_misc;
		mastership_request_n <= 1'b0;
		wait_grant(1'b0);
		grant_ack_n <= 1'b0;
		mastership_request_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		grant_ack_n <= 1'b1;
		wait_grant(1'b1);
		{irq_pin_mode, irq_mask_lvl, int_level_req_n} <= {7'h7F, 7'h7F, 7'h3F};
		repeat (5) @(posedge clk_sys);
		chk(irq_level, 3'h7);
		{irq_mask_lvl, int_level_req_n} <= {7'h00, 7'h7B};
		repeat (5) @(posedge clk_sys);
		chk(irq_level, 3'h3);
		sw_reset_req <= 1'b1;
		@(posedge clk_sys) sw_reset_req <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(reset_line_oe, 1'b1);
		repeat (12) begin @(posedge clk_sys); chk(ext_reset_seen, 1'b0); end
		chk(reset_line_oe, 1'b0);
		double_fault <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(suspend_n_oe, 1'b1);
		double_fault <= 1'b0;
	endtask
	// clock, then reset held ten cycles before the scenarios
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = !clk_sys;
	end
	initial begin
		{resetn, req_valid, req_read, req_locked, cs0_auto_vector_req_n_mode, sw_reset_req, double_fault} = 7'h00;
		{mastership_request_n, grant_ack_n, irq_pin_mode, irq_mask_lvl} = 16'hC000;
		{req_addr, req_wdata, cs_match, req_space, mode, req_size} = 52'h0;
		int_level_req_n = 7'h7F;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		t_writes();
		t_reads();
		t_misc();
		print_verdict();
	end
	// the run needs a few hundred cycles; this cuts a hang short at 20000
	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end
endmodule // testbench
